// >>> rtl/pqrt_defs.svh
// constants for the quad serial memory command interpreter
// assumes inclusion by rtl files that need opcodes and timing figures
`ifndef PQRT_DEFS_SVH
`define PQRT_DEFS_SVH

`define PQRT_OP_WRITE      8'h02
`define PQRT_OP_QWRITE     8'h38
`define PQRT_OP_ENTER_QUAD 8'h35
`define PQRT_OP_EXIT_QUAD  8'hf5
`define PQRT_OP_RST_ARM    8'h66
`define PQRT_OP_RST_EXEC   8'h99
`define PQRT_OP_WRAP_TOG   8'hc0

`define PQRT_CLK_PS        25000
`define PQRT_RST_REC_NS    50
`define PQRT_MAX_LOW_US    8
`define PQRT_REC_CYC       ((`PQRT_RST_REC_NS * 1000 + `PQRT_CLK_PS - 1) / `PQRT_CLK_PS)
`define PQRT_MAX_LOW_CYC   ((`PQRT_MAX_LOW_US * 1000000) / `PQRT_CLK_PS)

`define PQRT_SER_LAST      3'h7
`define PQRT_QUAD_LAST     3'h1

`endif

// >>> rtl/pqrt_pkg.sv
// types shared by the command interpreter
// assumes nothing beyond a systemverilog compiler
package pqrt_pkg;

    typedef enum logic {
        PQRT_OPCODE,
        PQRT_REST
    } pqrt_state_t;

    typedef struct packed {
        logic       valid;
        logic       quadWidth;
        logic [7:0] opcode;
    } pqrt_cmd_t;

endpackage

// >>> rtl/pqrt_cmd_interp.sv
// command interpreter of a quad serial pseudo-static memory
// assumes pins arrive asynchronously and sys_clk is much faster than the bus clock
`timescale 1ns/1ps
`include "pqrt_defs.svh"

module pqrt_cmd_interp (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               selectN,
    input  wire logic               busClk,
    input  wire logic [3:0]         sioIn,
    output logic      [3:0]         sioOut,
    output logic      [3:0]         sioOe,
    output logic                    quadEnabledFlag,
    output logic                    wrap32,
    output logic                    resetArmed,
    output logic                    softResetDone,
    output logic                    recoveryBusy,
    output logic                    selectLowOverrun,
    output pqrt_pkg::pqrt_cmd_t     cmdOut
);

    localparam int          REC_CYC = `PQRT_REC_CYC;
    localparam int          LOW_CYC = `PQRT_MAX_LOW_CYC;
    localparam logic [7:0]  REC_LD  = 8'(REC_CYC);
    localparam logic [15:0] LOW_MAX = 16'(LOW_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, a select or clock change counts once stages two and three agree

    logic [2:0] selSync;
    logic [2:0] clkSync;
    logic [3:0] io1;
    logic [3:0] io2;
    logic [3:0] io3;
    logic       selF;
    logic       clkF;
    logic [2:0] next_selSync;
    logic [2:0] next_clkSync;
    logic       next_selF;
    logic       next_clkF;
    logic       clkRise;

    always_comb begin
        next_selSync = {selSync[1:0], selectN};
        next_clkSync = {clkSync[1:0], busClk};
        next_selF    = (selSync[1] == selSync[2]) ? selSync[2] : selF;
        next_clkF    = (clkSync[1] == clkSync[2]) ? clkSync[2] : clkF;
        clkRise      = (clkSync[1] == clkSync[2]) && clkSync[2] && !clkF;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            selSync <= 3'h7;
            clkSync <= 3'h0;
            io1     <= 4'h0;
            io2     <= 4'h0;
            io3     <= 4'h0;
            selF    <= 1'h1;
            clkF    <= 1'h0;
        end else begin
            selSync <= next_selSync;
            clkSync <= next_clkSync;
            io1     <= sioIn;
            io2     <= io1;
            io3     <= io2;
            selF    <= next_selF;
            clkF    <= next_clkF;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // opcode collection and decode

    pqrt_pkg::pqrt_state_t st;
    pqrt_pkg::pqrt_state_t next_st;
    pqrt_pkg::pqrt_cmd_t   next_cmdOut;
    logic [7:0]            shiftReg;
    logic [7:0]            next_shiftReg;
    logic [2:0]            bitCnt;
    logic [2:0]            next_bitCnt;
    logic [7:0]            recCnt;
    logic [7:0]            next_recCnt;
    logic [15:0]           lowCnt;
    logic [15:0]           next_lowCnt;
    logic                  next_quad;
    logic                  next_wrap32;
    logic                  next_armed;
    logic                  next_resetDone;
    logic                  next_overrun;
    logic                  opDone;
    logic [7:0]            opNow;

    always_comb begin
        next_st        = st;
        next_shiftReg  = shiftReg;
        next_bitCnt    = bitCnt;
        next_recCnt    = (recCnt != 8'h0) ? recCnt - 8'h1 : recCnt;
        next_lowCnt    = lowCnt;
        next_quad      = quadEnabledFlag;
        next_wrap32    = wrap32;
        next_armed     = resetArmed;
        next_resetDone = 1'b0;
        next_overrun   = selectLowOverrun;
        next_cmdOut    = '0;
        opNow          = quadEnabledFlag ? {shiftReg[3:0], io3} : {shiftReg[6:0], io3[0]};
        opDone         = 1'b0;
        if (selF) begin
            next_st      = pqrt_pkg::PQRT_OPCODE;
            next_bitCnt  = 3'h0;
            next_lowCnt  = 16'h0;
            next_overrun = 1'b0;
        end else begin
            if (lowCnt >= LOW_MAX) begin
                next_overrun = 1'b1;
            end else begin
                next_lowCnt = lowCnt + 16'h1;
            end
            if (clkRise && st == pqrt_pkg::PQRT_OPCODE && recCnt == 8'h0) begin
                next_shiftReg = opNow;
                next_bitCnt   = bitCnt + 3'h1;
                opDone = quadEnabledFlag ? (bitCnt == `PQRT_QUAD_LAST)
                                         : (bitCnt == `PQRT_SER_LAST);
            end
        end
        if (opDone) begin
            next_st    = pqrt_pkg::PQRT_REST;
            next_armed = 1'b0;
            case (opNow)
                `PQRT_OP_RST_ARM: begin
                    next_armed = 1'b1;
                end
                `PQRT_OP_RST_EXEC: begin
                    if (resetArmed) begin
                        next_quad      = 1'b0;
                        next_wrap32    = 1'b0;
                        next_resetDone = 1'b1;
                        next_recCnt    = REC_LD;
                    end
                end
                `PQRT_OP_EXIT_QUAD: begin
                    if (quadEnabledFlag) begin
                        next_quad = 1'b0;
                    end
                end
                `PQRT_OP_ENTER_QUAD: begin
                    if (!quadEnabledFlag) begin
                        next_quad = 1'b1;
                    end
                end
                `PQRT_OP_WRAP_TOG: begin
                    next_wrap32 = !wrap32;
                end
                `PQRT_OP_WRITE, `PQRT_OP_QWRITE: begin
                    // no burst address kept here: page crossing is the data path's
                    next_cmdOut.valid     = 1'b1;
                    next_cmdOut.opcode    = opNow;
                    next_cmdOut.quadWidth = quadEnabledFlag || (opNow == `PQRT_OP_QWRITE);
                end
                default: begin
                    next_armed = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st               <= pqrt_pkg::PQRT_OPCODE;
            shiftReg         <= 8'h0;
            bitCnt           <= 3'h0;
            recCnt           <= 8'h0;
            lowCnt           <= 16'h0;
            quadEnabledFlag  <= 1'b0;
            wrap32           <= 1'b0;
            resetArmed       <= 1'b0;
            softResetDone    <= 1'b0;
            recoveryBusy     <= 1'b0;
            selectLowOverrun <= 1'b0;
            cmdOut           <= '0;
            sioOut           <= 4'h0;
            sioOe            <= 4'h0;
        end else begin
            st               <= next_st;
            shiftReg         <= next_shiftReg;
            bitCnt           <= next_bitCnt;
            recCnt           <= next_recCnt;
            lowCnt           <= next_lowCnt;
            quadEnabledFlag  <= next_quad;
            wrap32           <= next_wrap32;
            resetArmed       <= next_armed;
            softResetDone    <= next_resetDone;
            recoveryBusy     <= (next_recCnt != 8'h0);
            selectLowOverrun <= next_overrun;
            cmdOut           <= next_cmdOut;
            sioOut           <= 4'h0;
            sioOe            <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_quad_write_accept: assert property (@(posedge sys_clk) disable iff (rst)
        opDone && quadEnabledFlag
        && (opNow == `PQRT_OP_WRITE || opNow == `PQRT_OP_QWRITE)
        |=> cmdOut.valid && cmdOut.quadWidth && cmdOut.opcode == $past(opNow))
        else $error("quad write opcode not accepted as quad write");

    a_exit_quad: assert property (@(posedge sys_clk) disable iff (rst)
        opDone && quadEnabledFlag && opNow == `PQRT_OP_EXIT_QUAD
        |=> !quadEnabledFlag ##1 !quadEnabledFlag)
        else $error("exit opcode did not return to serial mode");

    a_exit_serial_ignored: assert property (@(posedge sys_clk) disable iff (rst)
        opDone && !quadEnabledFlag && opNow == `PQRT_OP_EXIT_QUAD
        |=> !quadEnabledFlag && !cmdOut.valid && !softResetDone && wrap32 == $past(wrap32))
        else $error("exit opcode acted on in serial mode");

    a_reset_standby: assert property (@(posedge sys_clk) disable iff (rst)
        softResetDone |-> !quadEnabledFlag && !wrap32 && recoveryBusy && !resetArmed)
        else $error("software reset did not give serial standby");

    a_reset_order: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(softResetDone) |-> $past(resetArmed) && $past(opNow) == `PQRT_OP_RST_EXEC)
        else $error("reset without directly preceding arm");

    a_arm_dropped: assert property (@(posedge sys_clk) disable iff (rst)
        opDone && resetArmed && opNow != `PQRT_OP_RST_ARM
        |=> !resetArmed)
        else $error("armed state kept after another command");

    a_select_idle: assert property (@(posedge sys_clk) disable iff (rst)
        selF |=> bitCnt == 3'h0 && st == pqrt_pkg::PQRT_OPCODE && !cmdOut.valid)
        else $error("partial command kept while deselected");

endmodule

// >>> dv/pqrt_host_model.sv
// host controller model driving select, bus clock and data pins
// assumes a fast sys_clk; every pin moves at its falling edge
`timescale 1ns/1ps

module pqrt_host_model (
    input  wire logic       sys_clk,
    output logic            selectN,
    output logic            busClk,
    output logic [3:0]      sioIn
);
    initial begin
        selectN = 1'b1;
        busClk = 1'b0;
        sioIn = 4'h0;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // select alone, no bus clock; no sleep entry is ever sent, so no exit
    // pulse or exit setup wait arises
    task automatic sel(input logic v);
        @(negedge sys_clk);
        selectN = v;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // one opcode frame, msb first; fewer units than a full opcode leaves it
    // partial; the frame is far shorter than the select-low limit
    task automatic frame(input logic [7:0] op, input logic quad, input int nUnits);
        logic [7:0] sh;
        sh = op;
        @(negedge sys_clk);
        selectN = 1'b0;
        idle(4);
        for (int i = 0; i < nUnits; i++) begin
            sioIn = quad ? sh[7:4] : {~sh[6:4], sh[7]};
            sh = quad ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
            idle(4);
            // bus clock period of 8 sys_clk is far above every minimum
            busClk = 1'b1;
            idle(4);
            busClk = 1'b0;
        end
        // select rises right after the last unit; released pins flip
        selectN = 1'b1;
        sioIn = ~sioIn;
        // deselect gap also covers recovery after a reset frame
        idle(12);
    endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench for the command interpreter
// assumes the host model drives the pins; outputs checked after frames
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin nFail++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end

module testbench;
    logic                sys_clk = 1'b0;
    logic                rst = 1'b1;
    wire logic           selectN;
    wire logic           busClk;
    wire logic [3:0]     sioIn;
    logic                quadFlag;
    logic                wrap32;
    logic                resetArmed;
    logic                softResetDone;
    logic                recBusy;
    logic                overrun;
    logic [3:0]          sioOe;
    int                  nBusy = 0;
    int                  m;
    pqrt_pkg::pqrt_cmd_t cmdOut;
    pqrt_pkg::pqrt_cmd_t lastCmd = '0;
    int                  nCmd = 0;
    int                  nDone = 0;
    int                  nFail = 0;
    int                  checked = 0;
    int                  n;

    always #12.5 sys_clk = ~sys_clk;

    pqrt_host_model pqrt_host_model_inst (
        .sys_clk (sys_clk),
        .selectN (selectN),
        .busClk  (busClk),
        .sioIn   (sioIn)
    );

    pqrt_cmd_interp pqrt_cmd_interp_inst (
        .sys_clk          (sys_clk),
        .rst              (rst),
        .selectN          (selectN),
        .busClk           (busClk),
        .sioIn            (sioIn),
        .sioOut           (),
        .sioOe            (sioOe),
        .quadEnabledFlag  (quadFlag),
        .wrap32           (wrap32),
        .resetArmed       (resetArmed),
        .softResetDone    (softResetDone),
        .recoveryBusy     (recBusy),
        .selectLowOverrun (overrun),
        .cmdOut           (cmdOut)
    );

    // one-cycle pulses are caught here
    always @(posedge sys_clk) begin
        if (cmdOut.valid === 1'b1) begin
            lastCmd <= cmdOut;
            nCmd <= nCmd + 1;
        end
        if (softResetDone === 1'b1) nDone <= nDone + 1;
        if (recBusy === 1'b1) nBusy <= nBusy + 1;
    end

    task automatic fr(input logic [7:0] op, input logic q, input int u);
        pqrt_host_model_inst.frame(op, q, u);
    endtask

    task automatic wr_chk(input logic [7:0] op, input logic q);
        n = nCmd;
        fr(op, q, q ? 2 : 8);
        `CHK("cmd count", n + 1, nCmd)
        `CHK("cmd", {1'b1, q | (op == 8'h38), op}, lastCmd)
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_quad_write;
        fr(8'h35, 1'b0, 8);
        `CHK("quad flag", 1'b1, quadFlag)
        wr_chk(8'h02, 1'b1);
        wr_chk(8'h38, 1'b1);
        $display("test quad_write done");
    endtask

    task automatic test_exit;
        fr(8'hf5, 1'b1, 2);
        `CHK("quad flag", 1'b0, quadFlag)
        wr_chk(8'h02, 1'b0);
        fr(8'hf5, 1'b0, 8);
        `CHK("quad flag", 1'b0, quadFlag)
        wr_chk(8'h38, 1'b0);
        $display("test exit done");
    endtask

    task automatic test_reset;
        fr(8'h35, 1'b0, 8);
        fr(8'hc0, 1'b1, 2);
        `CHK("wrap", 1'b1, wrap32)
        fr(8'h66, 1'b1, 2);
        `CHK("armed", 1'b1, resetArmed)
        n = nDone;
        m = nBusy;
        fr(8'h99, 1'b1, 2);
        `CHK("reset count", n + 1, nDone)
        `CHK("busy cycles", m + 2, nBusy)
        `CHK("quad flag", 1'b0, quadFlag)
        `CHK("wrap", 1'b0, wrap32)
        `CHK("armed", 1'b0, resetArmed)
        wr_chk(8'h02, 1'b0);
        $display("test reset done");
    endtask

    task automatic test_abort;
        fr(8'h35, 1'b0, 8);
        fr(8'h66, 1'b1, 2);
        fr(8'hc0, 1'b1, 2);
        `CHK("armed", 1'b0, resetArmed)
        n = nDone;
        fr(8'h99, 1'b1, 2);
        `CHK("reset count", n, nDone)
        `CHK("quad flag", 1'b1, quadFlag)
        $display("test abort done");
    endtask

    task automatic test_partial;
        fr(8'hf5, 1'b1, 1);
        wr_chk(8'h38, 1'b1);
        `CHK("quad flag", 1'b1, quadFlag)
        `CHK("oe", 4'h0, sioOe)
        $display("test partial done");
    endtask

    task automatic test_overrun;
        `CHK("overrun", 1'b0, overrun)
        pqrt_host_model_inst.sel(1'b0);
        pqrt_host_model_inst.idle(330);
        `CHK("overrun", 1'b1, overrun)
        pqrt_host_model_inst.sel(1'b1);
        pqrt_host_model_inst.idle(12);
        `CHK("overrun", 1'b0, overrun)
        $display("test overrun done");
    endtask

    task automatic complete_run;
        $display("checked %0d failed %0d", checked, nFail);
        if (nFail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        test_quad_write();
        test_exit();
        test_reset();
        test_abort();
        test_partial();
        test_overrun();
        complete_run();
    end

    // the tests need about 1300 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        nFail++;
        complete_run();
    end
endmodule
